// [hdl/csf_pkg.sv]
// Purpose: shared constants and carriers for the cpu status flag block
// Assumes: byte addresses on a 16-bit data-space port, word aligned
// Notes:   address map values are local to this block
package csf_pkg;

    // data-space byte addresses
    localparam logic [15:0] CSF_ADDR_W0       = 16'h0000;
    localparam logic [15:0] CSF_ADDR_W15      = 16'h001e;
    localparam logic [15:0] CSF_ADDR_LOOP_LO  = 16'h003a;
    localparam logic [15:0] CSF_ADDR_LOOP_HI  = 16'h003c;
    localparam logic [15:0] CSF_ADDR_STATUS   = 16'h0042;

    // status word field positions
    localparam int CSF_BIT_OA   = 15;
    localparam int CSF_BIT_OB   = 14;
    localparam int CSF_BIT_SA   = 13;
    localparam int CSF_BIT_SB   = 12;
    localparam int CSF_BIT_OAB  = 11;
    localparam int CSF_BIT_SAB  = 10;
    localparam int CSF_BIT_DA   = 9;
    localparam int CSF_BIT_DC   = 8;
    localparam int CSF_BIT_IPLH = 7;
    localparam int CSF_BIT_IPLL = 5;
    localparam int CSF_BIT_RA   = 4;
    localparam int CSF_BIT_N    = 3;
    localparam int CSF_BIT_OV   = 2;
    localparam int CSF_BIT_Z    = 1;
    localparam int CSF_BIT_C    = 0;

    localparam logic [15:0] CSF_STATUS_RESET = 16'h0000;
    localparam logic [15:0] CSF_WORD_RESET   = 16'h0000;
    localparam logic [2:0]  CSF_IPL_TOP      = 3'h7;
    localparam int          CSF_ALT_REGS     = 15;

    // one alu result report; flags apply only where their update bit is set
    typedef struct packed {
        logic updN;
        logic updOv;
        logic updZ;
        logic updC;
        logic updDc;
        logic resNeg;
        logic resZero;
        logic signedOvf;
        logic carryMsb;
        logic carry4;
        logic carry8;
        logic byteOp;
    } csf_alu_s;

    // dsp and loop sequencer levels, plus one-cycle saturation events
    typedef struct packed {
        logic [1:0] accOverflow;
        logic [1:0] accClip;
        logic       loopBlockActive;
        logic       repeatActive;
    } csf_core_s;

endpackage : csf_pkg

// [hdl/csf_status_regs.sv]
// Purpose: cpu status word and memory-mapped programmer's-model registers
// Assumes: one data-space access per cycle, reads answer one cycle later
// Notes:   working register contexts are chosen by the core, not here
//
// How it works
// - status bit 15 follows accumulator A overflow
// - status bit 14 follows accumulator B overflow
// - bit 13 sticks once accumulator A saturates
// - bit 12 sticks once accumulator B saturates
// - bit 11 reads as OR of both overflow flags
// - bit 10 reads as OR of both sticky saturation flags
// - status write sets saturation bits directly, or clears both via bit 10
// - bit 9 read-only, shows DO loop active
// - bit 8 half carry: bit 3 carry for bytes, bit 7 for words
// - bits 7..5 hold cpu priority level, level 7 blocks user interrupts
// - core msb joins priority bits into four-bit level; msb blocks all
// - priority bits read-only while nesting disable is set
// - bit 4 read-only, shows REPEAT loop active
// - bit 3 set on negative result, cleared otherwise
// - bit 2 flags signed overflow that flips the sign bit
// - bit 1 set by zero result, cleared by affecting non-zero result, loaded with bit 1 of a status write
// - bit 0 records carry out of the result msb
// - every register reachable as an ordinary data location
// - two alternate W0..W14 arrays; mapped view shows active context
// - loop start address registers are read-only to writes
// - carry and half carry act as borrow and digit borrow on subtract
module csf_status_regs
    import csf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // data-space access
    input  wire logic        memRead,
    input  wire logic        memWrite,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWdata,
    output logic      [15:0] memRdata,
    // core condition reports
    input  wire csf_alu_s    aluReport,
    input  wire csf_core_s   coreState,
    input  wire logic [1:0]  activeContext,
    input  wire logic        loopStartLoad,
    input  wire logic [23:0] loopStartValue,
    // interrupt controls
    input  wire logic        priorityLevelMsb,
    input  wire logic        nestingDisable,
    // status outputs
    output logic      [15:0] cpuStatusReg,
    output logic      [3:0]  cpuPriorityLevel,
    output logic             userIntDisable
);

    logic        oa,  ob,  sa,  sb,  da,  dc,  ra,  nf,  ov,  zf,  cf;
    logic [2:0]  cpu_priority_level;
    logic        next_oa, next_ob, next_sa, next_sb, next_da, next_dc;
    logic        next_ra, next_nf, next_ov, next_zf, next_cf;
    logic [2:0]  next_ipl;
    logic        srWrite;

    assign srWrite = memWrite && (memAddr == CSF_ADDR_STATUS);

    always_comb begin
        cpuStatusReg = CSF_STATUS_RESET;
        cpuStatusReg[CSF_BIT_OA]  = oa;
        cpuStatusReg[CSF_BIT_OB]  = ob;
        cpuStatusReg[CSF_BIT_SA]  = sa;
        cpuStatusReg[CSF_BIT_SB]  = sb;
        cpuStatusReg[CSF_BIT_OAB] = oa | ob;
        cpuStatusReg[CSF_BIT_SAB] = sa | sb;
        cpuStatusReg[CSF_BIT_DA]  = da;
        cpuStatusReg[CSF_BIT_DC]  = dc;
        cpuStatusReg[CSF_BIT_IPLH:CSF_BIT_IPLL] = cpu_priority_level;
        cpuStatusReg[CSF_BIT_RA]  = ra;
        cpuStatusReg[CSF_BIT_N]   = nf;
        cpuStatusReg[CSF_BIT_OV]  = ov;
        cpuStatusReg[CSF_BIT_Z]   = zf;
        cpuStatusReg[CSF_BIT_C]   = cf;
    end

    assign cpuPriorityLevel = {priorityLevelMsb, cpu_priority_level};
    assign userIntDisable   = priorityLevelMsb || (cpu_priority_level == CSF_IPL_TOP);

    always_comb begin
        next_oa = coreState.accOverflow[0];
        next_ob = coreState.accOverflow[1];
        next_da = coreState.loopBlockActive;
        next_ra = coreState.repeatActive;
        next_sa = sa;
        next_sb = sb;
        next_ipl = cpu_priority_level;
        next_dc = dc;
        next_nf = nf;
        next_ov = ov;
        next_zf = zf;
        next_cf = cf;
        if (srWrite) begin
            // direct write, a zero in bit 10 clears both
            next_sa = memWdata[CSF_BIT_SA] & memWdata[CSF_BIT_SAB];
            next_sb = memWdata[CSF_BIT_SB] & memWdata[CSF_BIT_SAB];
            // priority bits locked by nesting disable
            if (!nestingDisable) begin
                next_ipl = memWdata[CSF_BIT_IPLH:CSF_BIT_IPLL];
            end
            next_dc = memWdata[CSF_BIT_DC];
            next_nf = memWdata[CSF_BIT_N];
            next_ov = memWdata[CSF_BIT_OV];
            next_zf = memWdata[CSF_BIT_Z];
            next_cf = memWdata[CSF_BIT_C];
        end else begin
            // adder carry doubles as inverted digit borrow
            if (aluReport.updDc) begin
                next_dc = aluReport.byteOp ? aluReport.carry4
                                           : aluReport.carry8;
            end
            if (aluReport.updN) begin
                next_nf = aluReport.resNeg;
            end
            if (aluReport.updOv) begin
                next_ov = aluReport.signedOvf;
            end
            // zero flag, cleared only by non-zero result
            if (aluReport.updZ) begin
                next_zf = aluReport.resZero;
            end
            // carry out of msb, borrow sense on subtract
            if (aluReport.updC) begin
                next_cf = aluReport.carryMsb;
            end
        end
        // sticky set wins over a clearing write
        if (coreState.accClip[0]) begin
            next_sa = 1'b1;
        end
        // sticky set wins over a clearing write
        if (coreState.accClip[1]) begin
            next_sb = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            oa  <= 1'b0;
            ob  <= 1'b0;
            sa  <= 1'b0;
            sb  <= 1'b0;
            da  <= 1'b0;
            dc  <= 1'b0;
            cpu_priority_level <= 3'h0;
            ra  <= 1'b0;
            nf  <= 1'b0;
            ov  <= 1'b0;
            zf  <= 1'b0;
            cf  <= 1'b0;
        end else begin
            oa  <= next_oa;
            ob  <= next_ob;
            sa  <= next_sa;
            sb  <= next_sb;
            da  <= next_da;
            dc  <= next_dc;
            cpu_priority_level <= next_ipl;
            ra  <= next_ra;
            nf  <= next_nf;
            ov  <= next_ov;
            zf  <= next_zf;
            cf  <= next_cf;
        end
    end

    // working registers: primary 16 plus two alternate sets of 15
    logic [15:0] wPrim    [16];
    logic [15:0] wAlt     [2][CSF_ALT_REGS];
    logic [15:0] next_wPrim [16];
    logic [15:0] next_wAlt  [2][CSF_ALT_REGS];
    logic [23:0] loopStart;
    logic [23:0] next_loopStart;
    logic [15:0] next_memRdata;
    logic        wRange;
    logic [3:0]  wIdx;

    assign wRange = (memAddr[15:5] == CSF_ADDR_W0[15:5]) && !memAddr[0];
    assign wIdx   = memAddr[4:1];

    always_comb begin
        next_wPrim = wPrim;
        next_wAlt  = wAlt;
        // only the loop sequencer loads the start address
        next_loopStart = loopStartLoad ? loopStartValue : loopStart;
        next_memRdata  = CSF_WORD_RESET;
        // low fifteen follow the active context, W15 is shared
        if (memWrite && wRange) begin
            if (wIdx == 4'hf || activeContext == 2'h0) begin
                next_wPrim[wIdx] = memWdata;
            end else begin
                next_wAlt[activeContext[1]][wIdx] = memWdata;
            end
        end
        if (memRead) begin
            if (wRange) begin
                if (wIdx == 4'hf || activeContext == 2'h0) begin
                    next_memRdata = wPrim[wIdx];
                end else begin
                    next_memRdata = wAlt[activeContext[1]][wIdx];
                end
            end else if (memAddr == CSF_ADDR_STATUS) begin
                next_memRdata = cpuStatusReg;
            end else if (memAddr == CSF_ADDR_LOOP_LO) begin
                next_memRdata = loopStart[15:0];
            end else if (memAddr == CSF_ADDR_LOOP_HI) begin
                next_memRdata = {8'h00, loopStart[23:16]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                wPrim[i] <= CSF_WORD_RESET;
            end
            for (int i = 0; i < CSF_ALT_REGS; i++) begin
                wAlt[0][i] <= CSF_WORD_RESET;
                wAlt[1][i] <= CSF_WORD_RESET;
            end
            loopStart <= 24'h000000;
            memRdata  <= CSF_WORD_RESET;
        end else begin
            wPrim     <= next_wPrim;
            wAlt      <= next_wAlt;
            loopStart <= next_loopStart;
            memRdata  <= next_memRdata;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_oa_follows: assert property (
        coreState.accOverflow[0] |=> cpuStatusReg[CSF_BIT_OA])
        else $error("bit 15 missed accumulator A overflow");
    a_ob_clear: assert property (
        !coreState.accOverflow[1] |=> !cpuStatusReg[CSF_BIT_OB])
        else $error("bit 14 set without overflow");
    a_sa_sticky: assert property (
        cpuStatusReg[CSF_BIT_SA] && !srWrite |=> cpuStatusReg[CSF_BIT_SA])
        else $error("bit 13 lost without a write");
    a_sb_set: assert property (
        coreState.accClip[1] |=> cpuStatusReg[CSF_BIT_SB] [*1])
        else $error("bit 12 not set on saturation");
    a_oab_or: assert property (
        1'b1 |=> cpuStatusReg[CSF_BIT_OAB] ==
        ($past(coreState.accOverflow) != 2'h0))
        else $error("bit 11 is not the overflow OR");
    a_sab_clear: assert property (
        srWrite && !memWdata[CSF_BIT_SAB] && coreState.accClip == 2'b00
        |=> !cpuStatusReg[CSF_BIT_SAB])
        else $error("clearing bit 10 left saturation set");
    a_ipl_locked: assert property (
        nestingDisable |=> $stable(cpuStatusReg[CSF_BIT_IPLH:CSF_BIT_IPLL]))
        else $error("priority bits changed while locked");
    a_ra_ro: assert property (
        srWrite |=> cpuStatusReg[CSF_BIT_RA] == $past(coreState.repeatActive))
        else $error("bit 4 took a written value");
    a_dc_byte: assert property (
        !srWrite && aluReport.updDc && aluReport.byteOp
        |=> cpuStatusReg[CSF_BIT_DC] == $past(aluReport.carry4))
        else $error("byte half carry from wrong bit");
    a_z_clear: assert property (
        !srWrite && aluReport.updZ && !aluReport.resZero
        |=> !cpuStatusReg[CSF_BIT_Z])
        else $error("bit 1 not cleared by non-zero result");
    a_loop_ro: assert property (
        memWrite && !loopStartLoad |=> $stable(loopStart))
        else $error("loop start changed by a write");
    a_reset_zero: assert property (
        @(posedge clk) $fell(reset) |-> cpuStatusReg == CSF_STATUS_RESET)
        else $error("status word not zero after reset");

    c_clip_clear: cover property (srWrite && cpuStatusReg[CSF_BIT_SAB]);
    c_alt_write: cover property (memWrite && wRange && activeContext != 2'h0);
    c_locked_write: cover property (srWrite && nestingDisable);
    c_clip_on_write: cover property (srWrite && coreState.accClip != 2'h0);

endmodule : csf_status_regs

// [testbench/csf_core_model.sv]
// Purpose: stand-in for the alu, dsp engine and loop sequencer
// Assumes: drives just after the rising edge of clk
// Notes:   alu reports and clip events last one cycle, levels hold
module csf_core_model
    import csf_pkg::*;
(
    // clock
    input  wire logic clk,
    // condition reports
    output csf_alu_s  aluReport,
    output csf_core_s coreState
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        aluReport = '0;
        coreState = '0;
    end

    // one alu result; idle cycle after so reports never merge
    task automatic alu(input csf_alu_s r);
        aluReport = r;
        @(posedge clk) #1;
        aluReport = '0;
        @(posedge clk) #1;
    endtask : alu

    // saturation is an event, not a level
    task automatic clip(input logic [1:0] which);
        coreState.accClip = which;
        @(posedge clk) #1;
        coreState.accClip = 2'h0;
        @(posedge clk) #1;
    endtask : clip

    task automatic levels(input logic [1:0] ovf, input logic da, ra);
        coreState.accOverflow     = ovf;
        coreState.loopBlockActive = da;
        coreState.repeatActive    = ra;
        @(posedge clk) #1;
        @(posedge clk) #1;
    endtask : levels
endmodule : csf_core_model

// [testbench/csf_status_regs_tb.sv]
// Purpose: self-checking bench for the cpu status flag block
// Assumes: whole-word data-space accesses, one per two cycles
// Notes:   no alu report overlaps a status write
module csf_status_regs_tb
    import csf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, reset, memRead, memWrite, loopStartLoad;
    logic        priorityLevelMsb, nestingDisable, userIntDisable;
    logic [15:0] memAddr, memWdata, memRdata, cpuStatusReg, v;
    logic [1:0]  activeContext;
    logic [23:0] loopStartValue;
    logic [3:0]  cpuPriorityLevel;
    csf_alu_s    aluReport;
    csf_core_s   coreState;
    int          miscompares, tests_run;
    logic [11:0] aluIn[10] = '{12'h840, 12'hc10, 12'h220, 12'hc00,
        12'h200, 12'h108, 12'h185, 12'h084, 12'h082, 12'h083};
    logic [15:0] aluExp[10] = '{16'h0008, 16'h0004, 16'h0006, 16'h0002,
        16'h0000, 16'h0001, 16'h0100, 16'h0000, 16'h0100, 16'h0000};

    csf_core_model core (.clk(clk), .aluReport(aluReport),
        .coreState(coreState));

    csf_status_regs dut (.clk(clk), .reset(reset), .memRead(memRead),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata), .aluReport(aluReport),
        .coreState(coreState), .activeContext(activeContext),
        .loopStartLoad(loopStartLoad), .loopStartValue(loopStartValue),
        .priorityLevelMsb(priorityLevelMsb),
        .nestingDisable(nestingDisable), .cpuStatusReg(cpuStatusReg),
        .cpuPriorityLevel(cpuPriorityLevel),
        .userIntDisable(userIntDisable));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tick;
        @(posedge clk) #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk

    // idle cycle after each access so strobes never toggle twice at once
    task automatic wr(input logic [15:0] a, d);
        memWrite = 1'b1;
        memAddr  = a;
        memWdata = d;
        tick;
        memWrite = 1'b0;
        tick;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        memRead = 1'b1;
        memAddr = a;
        tick;
        d = memRdata;
        memRead = 1'b0;
        tick;
    endtask : rd

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up;
    end

    initial begin
        {reset, memRead, memWrite, loopStartLoad} = 4'h8;
        {priorityLevelMsb, nestingDisable} = 2'h0;
        {memAddr, memWdata, activeContext, loopStartValue} = '0;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        rd(CSF_ADDR_STATUS, v);
        chk(v, 16'h0000, "reset");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            core.levels(2'(i + 1), 1'b0, 1'b0);
            chk(cpuStatusReg, 16'h0800 | (i != 1 ? 16'h8000 : 16'h0000)
                | (i != 0 ? 16'h4000 : 16'h0000), "ovf");
        end
        core.levels(2'h0, 1'b0, 1'b0);
        wr(CSF_ADDR_STATUS, 16'hca10);
        chk(cpuStatusReg, 16'h0000, "ro bits");
        $display("test overflow done");
        core.clip(2'h1);
        tick;
        chk(cpuStatusReg, 16'h2400, "sat a");
        core.clip(2'h2);
        chk(cpuStatusReg, 16'h3400, "sat b");
        // whole-word writes only, never bit operations
        wr(CSF_ADDR_STATUS, 16'h3000);
        chk(cpuStatusReg, 16'h0000, "sat clr");
        wr(CSF_ADDR_STATUS, 16'h1400);
        chk(cpuStatusReg, 16'h1400, "sat set");
        // saturation event beats a clearing write
        fork
            core.clip(2'h1);
            wr(CSF_ADDR_STATUS, 16'h0000);
        join
        chk(cpuStatusReg, 16'h2400, "set wins");
        wr(CSF_ADDR_STATUS, 16'h0000);
        core.levels(2'h0, 1'b1, 1'b0);
        chk(cpuStatusReg, 16'h0200, "do loop");
        core.levels(2'h0, 1'b0, 1'b1);
        chk(cpuStatusReg, 16'h0010, "repeat");
        core.levels(2'h0, 1'b0, 1'b0);
        $display("test dsp flags done");
        for (int i = 0; i < 10; i++) begin
            core.alu(csf_alu_s'(aluIn[i]));
            chk(cpuStatusReg, aluExp[i], "alu");
        end
        $display("test alu done");
        for (int j = 0; j < 2; j++) begin
            priorityLevelMsb = j[0];
            for (int i = 0; i < 8; i++) begin
                wr(CSF_ADDR_STATUS, 16'(i << 5));
                chk(16'(cpuPriorityLevel), 16'(j * 8 + i), "ipl");
                chk(16'(userIntDisable), 16'(j | (i == 7)), "uid");
            end
        end
        nestingDisable = 1'b1;
        wr(CSF_ADDR_STATUS, 16'h0040);
        chk(cpuStatusReg, 16'h00e0, "ipl lock");
        nestingDisable = 1'b0;
        $display("test priority done");
        for (int c = 0; c < 3; c++) begin
            activeContext = 2'(c);
            for (int i = 0; i < (c == 0 ? 16 : 15); i++)
                wr(CSF_ADDR_W0 + 16'(2 * i), 16'(4096 * (c + 1) + i));
        end
        for (int c = 0; c < 4; c++) begin
            activeContext = 2'(c);
            for (int i = 0; i < 16; i++) begin
                rd(CSF_ADDR_W0 + 16'(2 * i), v);
                chk(v, i == 15 ? 16'h100f
                    : 16'(4096 * ((c > 2 ? 2 : c) + 1) + i), "w");
            end
        end
        $display("test working regs done");
        loopStartLoad  = 1'b1;
        loopStartValue = 24'habcdef;
        tick;
        loopStartLoad = 1'b0;
        wr(CSF_ADDR_LOOP_LO, 16'h1234);
        wr(CSF_ADDR_LOOP_HI, 16'h5678);
        rd(CSF_ADDR_LOOP_LO, v);
        chk(v, 16'hcdef, "loop lo");
        rd(CSF_ADDR_LOOP_HI, v);
        chk(v, 16'h00ab, "loop hi");
        rd(16'h0100, v);
        chk(v, 16'h0000, "unmapped");
        $display("test loop start done");
        wrap_up;
    end
endmodule : csf_status_regs_tb
